// *** gx_pkg.sv ***
// Shared constants, types and state layout for the 16-bit two-wire I/O expander
// How it works
// - Answer only addresses matching the three straps
// - Address last bit: one reads, zero writes
// - Byte after write address loads the pointer
// - Pointer is write-only, never read back
// - Registers 0/1 return pin levels, ignore writes
// - Registers 2/3 hold drive levels, read back stored
// - Registers 4/5 invert reported input levels
// - Registers 6/7: one input, zero output
// - Outputs drive stored level; inputs float
// - Reset: drive and direction ones, inversion zeros
// - Input pin edge raises the alert
// - Alert clears on revert or port read
// - Read clear happens at acknowledge rising edge
// - Later input changes raise alert again
// - Output pins never alert; direction switch may
// - Write bytes alternate within register pair
// - Unlimited bytes per transfer, still alternating
// - Read bytes alternate within register pair
// - Input sample latched at acknowledge falling edge
// - Restarted read continues at following pair register
// - Alert pin open-drain, active low
// - Bus runs up to fast-mode rates
package gx_pkg;

  localparam int SYS_CLK_MHZ = 250;
  localparam int BUS_MAX_KHZ = 400;
  // Bus clock is oversampled; each bus half period spans hundreds of system cycles
  localparam int SCL_HALF_CYC = (SYS_CLK_MHZ * 1000) / (BUS_MAX_KHZ * 2);

  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_INV0 = 3'h4;
  localparam logic [2:0] REG_INV1 = 3'h5;
  localparam logic [2:0] REG_DIR0 = 3'h6;
  localparam logic [2:0] REG_DIR1 = 3'h7;

  localparam logic [7:0] OUT_RST = 8'hFF;
  localparam logic [7:0] INV_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;

  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] PRIME_DONE = 2'h3;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } gx_port_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_WR,
    PH_ACK,
    PH_RD,
    PH_RD_ACK,
    PH_SKIP
  } gx_phase_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    gx_port_t pin_s1;
    gx_port_t pin_s2;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    gx_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rd_mode;
    logic cmd_done;
    logic acked;
    logic [2:0] pointer;
    gx_port_t out_drive;
    gx_port_t invert;
    gx_port_t direction;
    gx_port_t in_latch;
    logic [1:0] prime_cnt;
    logic drive_low;
    logic alert;
  } gx_state_t;

endpackage

// *** gx_expander.sv ***
// Two-wire slave 16-bit I/O expander with change alert
`timescale 1ns/10ps
module gx_expander import gx_pkg::*; #(
  // Fixed upper address bits; value is arbitrary
  parameter logic [3:0] DEV_ADDR_HI = 4'h2
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic [7:0] lower_port_pin_in,
  output logic [7:0] lower_port_pin_out,
  output logic [7:0] lower_port_pin_oe_n,
  input wire logic [7:0] upper_port_pin_in,
  output logic [7:0] upper_port_pin_out,
  output logic [7:0] upper_port_pin_oe_n,
  output logic alert_out,
  output logic alert_oe_n
);

  gx_state_t st;
  gx_state_t next_st;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic addr_hit;
  logic byte_end;
  gx_port_t pin_change;

  // Edges of the sampled bus lines; start and stop are data moves while clock is high
  assign scl_rise = st.scl_s2 & ~st.scl_d;
  assign scl_fall = ~st.scl_s2 & st.scl_d;
  assign bus_start = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
  assign bus_stop = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;
  assign byte_end = scl_fall && (st.bitcnt == BIT_LAST);
  assign addr_hit = (st.shreg[7:1] == {DEV_ADDR_HI, st.strap_s2});
  // Only input-configured pins count as differing from their latched level
  assign pin_change = (st.pin_s2 ^ st.in_latch) & st.direction;

  // Loads the byte to transmit; input ports snapshot the pins here
  function automatic gx_state_t load_byte(input gx_state_t s);
    gx_state_t r;
    logic [7:0] val;
    r = s;
    val = 8'h00;
    case (s.pointer)
      REG_IN0: begin
        r.in_latch.lower = s.pin_s2.lower;
        val = s.pin_s2.lower ^ s.invert.lower;
      end
      REG_IN1: begin
        r.in_latch.upper = s.pin_s2.upper;
        val = s.pin_s2.upper ^ s.invert.upper;
      end
      REG_OUT0: val = s.out_drive.lower;
      REG_OUT1: val = s.out_drive.upper;
      REG_INV0: val = s.invert.lower;
      REG_INV1: val = s.invert.upper;
      REG_DIR0: val = s.direction.lower;
      REG_DIR1: val = s.direction.upper;
      default: val = 8'h00;
    endcase
    // Pointer itself is never a source of read data
    r.shreg = val;
    r.drive_low = ~val[7];
    r.bitcnt = 4'h0;
    r.phase = PH_RD;
    return r;
  endfunction

  always_comb begin
    next_st = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;
    next_st.pin_s1 = {upper_port_pin_in, lower_port_pin_in};
    next_st.pin_s2 = st.pin_s1;
    next_st.strap_s1 = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    next_st.strap_s2 = st.strap_s1;

    // Input latch tracks the pins until the synchronisers have filled after reset
    if (st.prime_cnt != PRIME_DONE) begin
      next_st.prime_cnt = st.prime_cnt + 2'h1;
      next_st.in_latch = st.pin_s2;
    end

    if (bus_start) begin
      // Repeated start keeps the pointer so a read resumes where it left off
      next_st.phase = PH_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.cmd_done = 1'b0;
      next_st.drive_low = 1'b0;
    end else if (bus_stop) begin
      next_st.phase = PH_IDLE;
      next_st.drive_low = 1'b0;
    end else begin
      case (st.phase)
        PH_IDLE, PH_SKIP: begin
        end
        PH_ADDR, PH_CMD, PH_WR: begin
          if (scl_rise && st.bitcnt != BIT_LAST) begin
            next_st.shreg = {st.shreg[6:0], st.sda_s2};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (byte_end) begin
            next_st.bitcnt = 4'h0;
            next_st.drive_low = 1'b1;
            next_st.phase = PH_ACK;
            case (st.phase)
              PH_ADDR: begin
                if (addr_hit) begin
                  next_st.rd_mode = st.shreg[0];
                end else begin
                  next_st.drive_low = 1'b0;
                  next_st.phase = PH_SKIP;
                end
              end
              PH_CMD: begin
                // Upper command bits are dropped, so no undefined register exists
                next_st.pointer = st.shreg[2:0];
                next_st.cmd_done = 1'b1;
              end
              default: begin
                case (st.pointer)
                  REG_OUT0: next_st.out_drive.lower = st.shreg;
                  REG_OUT1: next_st.out_drive.upper = st.shreg;
                  REG_INV0: next_st.invert.lower = st.shreg;
                  REG_INV1: next_st.invert.upper = st.shreg;
                  REG_DIR0: next_st.direction.lower = st.shreg;
                  REG_DIR1: next_st.direction.upper = st.shreg;
                  default: begin
                  end
                endcase
                next_st.pointer = st.pointer ^ 3'h1;
              end
            endcase
          end
        end
        PH_ACK: begin
          if (scl_fall) begin
            next_st.drive_low = 1'b0;
            if (st.rd_mode) begin
              next_st = load_byte(next_st);
            end else begin
              next_st.phase = st.cmd_done ? PH_WR : PH_CMD;
            end
          end
        end
        PH_RD: begin
          if (scl_rise) begin
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (st.bitcnt == BIT_LAST) begin
              next_st.drive_low = 1'b0;
              next_st.bitcnt = 4'h0;
              next_st.phase = PH_RD_ACK;
            end else begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.drive_low = ~st.shreg[6];
            end
          end
        end
        PH_RD_ACK: begin
          if (scl_rise) begin
            next_st.acked = ~st.sda_s2;
            // Reading an input port re-latches it, which clears its alert
            if (st.pointer == REG_IN0) begin
              next_st.in_latch.lower = st.pin_s2.lower;
            end else if (st.pointer == REG_IN1) begin
              next_st.in_latch.upper = st.pin_s2.upper;
            end
            next_st.pointer = st.pointer ^ 3'h1;
          end else if (scl_fall) begin
            // A missing acknowledge ends the read and frees the data line
            if (st.acked) begin
              next_st = load_byte(next_st);
            end else begin
              next_st.phase = PH_SKIP;
            end
          end
        end
        default: next_st.phase = PH_IDLE;
      endcase
    end

    // One-cycle register acts as the settling delay before the pin moves
    next_st.alert = |pin_change;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.scl_s1 <= 1'b1;
      st.scl_s2 <= 1'b1;
      st.scl_d <= 1'b1;
      st.sda_s1 <= 1'b1;
      st.sda_s2 <= 1'b1;
      st.sda_d <= 1'b1;
      st.phase <= PH_IDLE;
      st.out_drive <= {OUT_RST, OUT_RST};
      st.invert <= {INV_RST, INV_RST};
      st.direction <= {DIR_RST, DIR_RST};
    end else begin
      st <= next_st;
    end
  end

  // Open-drain lines only ever pull low; enables are active low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~st.drive_low;
  assign alert_out = 1'b0;
  assign alert_oe_n = ~st.alert;
  assign lower_port_pin_out = st.out_drive.lower;
  assign upper_port_pin_out = st.out_drive.upper;
  assign lower_port_pin_oe_n = st.direction.lower;
  assign upper_port_pin_oe_n = st.direction.upper;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_addr_end;
    st.phase == PH_ADDR && byte_end;
  endsequence

  sequence s_rd_ack_rise;
    st.phase == PH_RD_ACK && scl_rise && !bus_start && !bus_stop;
  endsequence

  sequence s_wr_end;
    st.phase == PH_WR && byte_end && !bus_start && !bus_stop;
  endsequence

  chk_addr_miss: assert property (s_addr_end and (!addr_hit && !bus_start && !bus_stop) |=> st.phase == PH_SKIP ##0 sda_oe_n)
    else $error("Foreign address was acknowledged");
  chk_addr_ack: assert property (s_addr_end and (addr_hit && !bus_start && !bus_stop) |=> !sda_oe_n && st.rd_mode == $past(st.shreg[0]))
    else $error("Own address not acknowledged or direction wrong");
  chk_ptr_load: assert property (st.phase == PH_CMD && byte_end && !bus_start && !bus_stop |=> st.pointer == $past(st.shreg[2:0]) && st.phase == PH_ACK)
    else $error("Command byte did not load the pointer");
  chk_input_ro: assert property (s_wr_end and (st.pointer[2:1] == 2'b00) |=> $stable(st.out_drive) && $stable(st.invert) && $stable(st.direction))
    else $error("Write to input register changed state");
  chk_wr_alternate: assert property (s_wr_end |=> st.pointer == ($past(st.pointer) ^ 3'h1))
    else $error("Write did not alternate within pair");
  chk_rd_alternate: assert property (s_rd_ack_rise |=> st.pointer == ($past(st.pointer) ^ 3'h1))
    else $error("Read did not alternate within pair");
  chk_read_clear: assert property (s_rd_ack_rise and (st.pointer == REG_IN0) |=> st.in_latch.lower == $past(st.pin_s2.lower))
    else $error("Port read did not clear its change");
  chk_alert_set: assert property ((|pin_change) |=> !alert_oe_n)
    else $error("Input change did not raise alert");
  chk_alert_idle: assert property ((pin_change == 16'h0000) |=> alert_oe_n)
    else $error("Alert raised without an input change");
  chk_drive_hold: assert property (!(st.phase == PH_WR && byte_end) |=> $stable(lower_port_pin_out) && $stable(upper_port_pin_oe_n))
    else $error("Pad drive changed without a register write");

endmodule

// *** gx_master.sv ***
// Behavioural two-wire bus master standing on the expander's far side
`timescale 1ns/10ps
module gx_master (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // One quarter of the 64 ns bus period
  task automatic q(input int n);
    repeat (4 * n) @(negedge sys_clk);
  endtask

  // Data moves only mid-low so it never races the clock through the synchronisers
  task automatic bit_io(input logic b, output logic seen);
    q(1);
    sda_pull = !b;
    q(1);
    scl = 1'b1;
    q(1);
    seen = sda;
    q(1);
    scl = 1'b0;
  endtask

  // Begins only from an idle bus left by a stop or by reset
  task automatic start();
    q(1);
    sda_pull = 1'b1;
    q(2);
    scl = 1'b0;
  endtask

  task automatic restart();
    q(1);
    sda_pull = 1'b0;
    q(1);
    scl = 1'b1;
    q(1);
    sda_pull = 1'b1;
    q(1);
    scl = 1'b0;
  endtask

  task automatic stop();
    q(1);
    sda_pull = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    sda_pull = 1'b0;
    q(2);
  endtask

  // Ack slot level: 1 releases (write, or final read byte), 0 acknowledges
  task automatic byte_io(input logic [7:0] tx, input logic ack_lvl, output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_lvl, ack_seen);
  endtask
endmodule

// *** gx_expander_tb.sv ***
// Self-checking testbench for the two-wire 16-bit I/O expander
`timescale 1ns/10ps
module gx_expander_tb import gx_pkg::*;;
  // Upper address value is arbitrary
  localparam logic [3:0] DEV_HI = 4'h9;
  localparam logic [2:0] STRAP = 3'h5;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = STRAP;
  logic [7:0] ext_lo = 8'hA0;
  logic [7:0] ext_hi = 8'h3C;
  logic scl, sda_pull, sda_out, sda_oe_n, alert_out, alert_oe_n;
  logic [7:0] lo_out, lo_oe_n, hi_out, hi_oe_n;
  logic [15:0] d;
  int mismatches = 0;
  int compares = 0;
  // Pull-up on the data line; port pins follow the driver only where it is enabled
  wire sda = !(sda_pull || !sda_oe_n);
  wire [7:0] lo_in = (lo_oe_n & ext_lo) | (~lo_oe_n & lo_out);
  wire [7:0] hi_in = (hi_oe_n & ext_hi) | (~hi_oe_n & hi_out);

  always #2 sys_clk = !sys_clk;

  gx_master i_gx_master (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  gx_expander #(.DEV_ADDR_HI(DEV_HI)) i_gx_expander (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .lower_port_pin_in(lo_in), .lower_port_pin_out(lo_out), .lower_port_pin_oe_n(lo_oe_n),
    .upper_port_pin_in(hi_in), .upper_port_pin_out(hi_out), .upper_port_pin_oe_n(hi_oe_n),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] rx;
    logic k;
    i_gx_master.start();
    i_gx_master.byte_io({DEV_HI, STRAP, 1'b0}, 1'b1, rx, k);
    check("write address ack", 16'(k), 16'h0000);
    i_gx_master.byte_io(cmd, 1'b1, rx, k);
    i_gx_master.byte_io(a, 1'b1, rx, k);
    i_gx_master.byte_io(b, 1'b1, rx, k);
    check("data ack", 16'(k), 16'h0000);
    i_gx_master.stop();
  endtask

  task automatic rd(input logic use_cmd, input logic [7:0] cmd, input logic two, output logic [15:0] v);
    logic [7:0] rx;
    logic k;
    i_gx_master.start();
    if (use_cmd) begin
      i_gx_master.byte_io({DEV_HI, STRAP, 1'b0}, 1'b1, rx, k);
      i_gx_master.byte_io(cmd, 1'b1, rx, k);
      i_gx_master.restart();
    end
    i_gx_master.byte_io({DEV_HI, STRAP, 1'b1}, 1'b1, rx, k);
    check("read address ack", 16'(k), 16'h0000);
    i_gx_master.byte_io(8'hFF, !two, v[15:8], k);
    if (two) i_gx_master.byte_io(8'hFF, 1'b1, v[7:0], k);
    i_gx_master.stop();
  endtask

  task automatic alert_is(input logic exp);
    repeat (8) @(negedge sys_clk);
    check("alert", 16'(alert_oe_n), 16'(exp));
    check("alert level", 16'(alert_out), 16'h0000);
  endtask

  task automatic t_reset();
    check("pin drive", {hi_out, lo_out}, 16'hFFFF);
    check("pin enable", {hi_oe_n, lo_oe_n}, 16'hFFFF);
    rd(1'b1, 8'h02, 1'b1, d);
    check("output pair", d, 16'hFFFF);
    rd(1'b1, 8'h04, 1'b1, d);
    check("invert pair", d, 16'h0000);
    rd(1'b1, 8'h06, 1'b1, d);
    check("direction pair", d, 16'hFFFF);
    $display("test reset done");
  endtask

  task automatic t_input();
    wr(8'h04, 8'hFF, 8'h00);
    rd(1'b1, 8'h00, 1'b1, d);
    check("input pair", d, 16'h5F3C);
    rd(1'b1, 8'h01, 1'b1, d);
    check("input pair from 1", d, 16'h3C5F);
    rd(1'b0, 8'h00, 1'b0, d);
    check("continued read", 16'(d[15:8]), 16'h003C);
    wr(8'h00, 8'h00, 8'h00);
    rd(1'b1, 8'hF8, 1'b1, d);
    check("input after write", d, 16'h5F3C);
    wr(8'h04, 8'h00, 8'h00);
    $display("test input done");
  endtask

  task automatic t_alert();
    rd(1'b1, 8'h00, 1'b1, d);
    alert_is(1'b1);
    ext_lo = 8'hA1;
    alert_is(1'b0);
    ext_lo = 8'hA0;
    alert_is(1'b1);
    ext_hi = 8'hBC;
    alert_is(1'b0);
    rd(1'b1, 8'h01, 1'b0, d);
    check("latched sample", 16'(d[15:8]), 16'h00BC);
    alert_is(1'b1);
    ext_hi = 8'h3C;
    alert_is(1'b0);
    rd(1'b1, 8'h01, 1'b0, d);
    alert_is(1'b1);
    $display("test alert done");
  endtask

  task automatic t_write();
    wr(8'h03, 8'hA5, 8'h3C);
    wr(8'hF6, 8'h00, 8'h0F);
    check("pin drive", {hi_out, lo_out}, 16'hA53C);
    check("pin enable", {hi_oe_n, lo_oe_n}, 16'h0F00);
    alert_is(1'b1);
    rd(1'b1, 8'h02, 1'b1, d);
    check("output readback", d, 16'h3CA5);
    rd(1'b1, 8'h01, 1'b0, d);
    check("mixed pin levels", 16'(d[15:8]), 16'h00AC);
    wr(8'h06, 8'hFF, 8'hFF);
    alert_is(1'b0);
    rd(1'b1, 8'h00, 1'b1, d);
    alert_is(1'b1);
    $display("test write done");
  endtask

  task automatic t_addr();
    logic [7:0] rx;
    logic k;
    i_gx_master.start();
    i_gx_master.byte_io({DEV_HI, 3'h4, 1'b0}, 1'b1, rx, k);
    check("foreign address ack", 16'(k), 16'h0001);
    i_gx_master.stop();
    $display("test address done");
  endtask

  initial begin
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_reset();
    t_input();
    t_alert();
    t_write();
    t_addr();
    give_verdict();
  end

  // Whole run needs roughly 52 us of bus traffic
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
